// File: pic_ctrl_defines.vh
// constants for the picture encode command and completion block
// assumes inclusion by bare name from the design file
`ifndef PIC_CTRL_DEFINES_VH
`define PIC_CTRL_DEFINES_VH
`define OFS_CMD       12'h000
`define OFS_YBASE     12'h004
`define OFS_CBBASE    12'h008
`define OFS_CRBASE    12'h00c
`define OFS_QSTEP     12'h010
`define OFS_OPTS      12'h014
`define OFS_CFG       12'h018
`define OFS_BUSY      12'h01c
`define OFS_INTEN     12'h020
`define OFS_INTSTAT   12'h024
`define OFS_RDPTR     12'h028
`define OFS_WRPTR     12'h02c
`define OFS_RESFETCH  12'h030
`define OFS_DYNPARAM  12'h034
`define OFS_PARBUF    12'h100
`define CMD_PIC_RUN   4'h1
`define CMD_CLOSE     4'h2
`define CMD_DYNAMIC   4'h3
`define CMD_SEQ_INIT  4'h4
`define OPT_SKIP      0
`define OPT_INTRA     1
`define CFG_RC        0
`define CFG_RING      1
`define CFG_STD_LO    2
`define CFG_STD_HI    3
`define CFG_FMT_LO    4
`define CFG_FMT_HI    6
`define CFG_REPORT    7
`define STD_H263      2'h1
`define STD_MPEG4     2'h2
`define FMT_422V      3'h2
`define FMT_420       3'h0
`define INT_PIC_DONE  3
`define INT_REFUSED   0
`define INT_STALL     1
`define PTYPE_I       2'h0
`define PTYPE_P       2'h1
`define PTYPE_SKIP    2'h2
`define PB_PTYPE      3'h0
`define PB_SLICES     3'h1
`define PB_START      3'h2
`define PB_SIZE       3'h3
`define PB_SLBND      3'h4
`define PB_MBBND      3'h5
`define PB_QP         3'h6
`define PB_QP_EN      3'h7
`define ENC_WORK      16'h0010
`define CHUNK_BYTES   32'h00000040
`define QSTEP_RC      6'h1a
`define OFS_END       12'h038
`define PB_PAGE       7'h08
`define DYN_FORCE_I   8
`define SKIP_WORK     16'h0001
`endif

// File: video_encoder_picture_control.v
// picture encode command interpreter with busy flag, interrupt and results
// assumes an apb master on clk; the codec datapath is modelled by a cycle count
`timescale 1ns/1ns
`include "pic_ctrl_defines.vh"
module video_encoder_picture_control (
    // clock and reset
    input  wire        clk,
    input  wire        rst_b,
    // apb slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output wire        pready,
    output reg  [31:0] prdata,
    output wire        pslverr,
    // interrupt
    output wire        irq,
    // stream buffer geometry
    input  wire [31:0] streamBase,
    input  wire [31:0] streamSize
);
    localparam IDLE = 4'b0001;
    localparam RUN  = 4'b0010;
    localparam WRES = 4'b0100;
    localparam HOLD = 4'b1000;

    reg [3:0]  state_r;
    reg [31:0] yBase_r;
    reg [31:0] cbBase_r;
    reg [31:0] crBase_r;
    reg [5:0]  qstep_r;
    reg [1:0]  opts_r;
    reg [7:0]  cfg_r;
    reg [31:0] intEn_r;
    reg [31:0] intStat_r;
    reg [31:0] rdPtr_r;
    reg [31:0] wrPtr_r;
    reg [31:0] picStart_r;
    reg [15:0] workCnt_r;
    reg [15:0] slices_r;
    reg        open_r;
    reg [31:0] dynParam_r;
    reg [2:0]  pbIdx_r;
    reg [31:0] parBuf_r [0:7];
    reg [1:0]  pType_r;
    reg [5:0]  qUsed_r;
    reg        gopFirst_r;
    // next values decided by combinational logic
    reg [1:0]  pType_nxt;
    reg [5:0]  qUsed_nxt;
    reg [15:0] workCnt_nxt;
    reg [31:0] pbWord_nxt;

    // bus decode and status
    wire        access;
    wire        wr;
    wire        rd;
    wire        busy;
    wire        ring;
    wire [1:0]  std;
    wire [2:0]  fmt;
    wire [2:0]  encFmt;
    wire [31:0] used;
    wire        full;
    wire        cmdWr;
    wire [3:0]  cmd;
    wire        refuse;
    wire        runOk;
    wire        done;
    wire        mapped;

    assign access = psel && penable;
    assign wr     = access && pwrite;
    assign rd     = access && !pwrite;
    assign busy   = (state_r == RUN) || (state_r == WRES);
    assign ring   = cfg_r[`CFG_RING];
    assign std    = cfg_r[`CFG_STD_HI:`CFG_STD_LO];
    assign fmt    = cfg_r[`CFG_FMT_HI:`CFG_FMT_LO];
    // internal format after conversion
    assign encFmt = (fmt == `FMT_422V) ? `FMT_420 : fmt;
    assign used   = wrPtr_r - rdPtr_r;
    assign full   = ring && (used + `CHUNK_BYTES > streamSize);
    assign cmdWr  = wr && (paddr == `OFS_CMD);
    assign cmd    = pwdata[3:0];
    // refused while busy, while results unfetched, or, except sequence init, without an open instance
    assign refuse = cmdWr && (busy || (state_r == HOLD) || !open_r) &&
                    !(cmd == `CMD_SEQ_INIT && !busy && state_r != HOLD);
    assign runOk  = cmdWr && !refuse && cmd == `CMD_PIC_RUN;
    assign done   = (state_r == WRES) && (pbIdx_r == `PB_QP_EN);
    assign mapped = (paddr < `OFS_END) || (paddr[11:5] == `PB_PAGE);

    // zero wait states; errors only for unmapped offsets
    assign pready  = 1'b1;
    assign pslverr = access && !mapped;
    assign irq     = |(intStat_r & intEn_r);

    // picture type, work length and quantiser chosen at the run command
    always @* begin
        pType_nxt   = `PTYPE_P;
        workCnt_nxt = `ENC_WORK;
        qUsed_nxt   = cfg_r[`CFG_RC] ? `QSTEP_RC : qstep_r;
        if (opts_r[`OPT_SKIP]) begin
            pType_nxt   = `PTYPE_SKIP;
            workCnt_nxt = `SKIP_WORK;
        end else if (opts_r[`OPT_INTRA] || gopFirst_r) begin
            pType_nxt = `PTYPE_I;
        end
    end

    // read data straight from the registers
    always @* begin
        prdata = 32'h00000000;
        case (paddr)
            `OFS_YBASE:    prdata = yBase_r;
            `OFS_CBBASE:   prdata = cbBase_r;
            `OFS_CRBASE:   prdata = crBase_r;
            `OFS_QSTEP:    prdata = {26'h0, qstep_r};
            `OFS_OPTS:     prdata = {30'h0, opts_r};
            `OFS_CFG:      prdata = {21'h0, encFmt, cfg_r};
            `OFS_BUSY:     prdata = {30'h0, open_r, busy};
            `OFS_INTEN:    prdata = intEn_r;
            `OFS_INTSTAT:  prdata = intStat_r;
            `OFS_RDPTR:    prdata = rdPtr_r;
            `OFS_WRPTR:    prdata = wrPtr_r;
            `OFS_DYNPARAM: prdata = dynParam_r;
            default: begin
                if (paddr[11:5] == `PB_PAGE) begin
                    prdata = parBuf_r[paddr[4:2]];
                end
            end
        endcase
    end

    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_r    <= IDLE;
            yBase_r    <= 32'h00000000;
            cbBase_r   <= 32'h00000000;
            crBase_r   <= 32'h00000000;
            qstep_r    <= 6'h00;
            opts_r     <= 2'h0;
            cfg_r      <= 8'h00;
            intEn_r    <= 32'h00000000;
            intStat_r  <= 32'h00000000;
            rdPtr_r    <= 32'h00000000;
            wrPtr_r    <= 32'h00000000;
            picStart_r <= 32'h00000000;
            workCnt_r  <= 16'h0000;
            slices_r   <= 16'h0000;
            open_r     <= 1'b0;
            dynParam_r <= 32'h00000000;
            pbIdx_r    <= 3'h0;
            pType_r    <= 2'h0;
            qUsed_r    <= 6'h00;
            gopFirst_r <= 1'b1;
        end else begin
            // parameter loads, ignored while an encode is in flight
            if (wr && !busy) begin
                case (paddr)
                    `OFS_YBASE:  yBase_r  <= pwdata;
                    `OFS_CBBASE: cbBase_r <= pwdata;
                    `OFS_CRBASE: crBase_r <= pwdata;
                    `OFS_QSTEP:  qstep_r  <= pwdata[5:0];
                    `OFS_OPTS:   opts_r   <= pwdata[1:0];
                    `OFS_CFG:    cfg_r    <= pwdata[7:0];
                    default: ;
                endcase
            end
            if (wr && paddr == `OFS_INTEN) begin
                intEn_r <= pwdata;
            end
            // host writes move the read pointer only in ring mode
            if (wr && paddr == `OFS_RDPTR && ring) begin
                rdPtr_r <= pwdata;
            end
            // read clears status; new events win over the clear
            if (rd && paddr == `OFS_INTSTAT) begin
                intStat_r <= 32'h00000000;
            end
            if (refuse) begin
                intStat_r[`INT_REFUSED] <= 1'b1;
            end
            // command decode; refused commands only flag an error
            if (cmdWr && !refuse) begin
                case (cmd)
                    `CMD_SEQ_INIT: begin
                        open_r     <= 1'b1;
                        gopFirst_r <= 1'b1;
                        rdPtr_r    <= streamBase;
                        wrPtr_r    <= streamBase;
                    end
                    `CMD_CLOSE: open_r <= 1'b0;
                    `CMD_DYNAMIC: begin
                        dynParam_r <= pwdata;
                        if (pwdata[`DYN_FORCE_I]) begin
                            gopFirst_r <= 1'b1;
                        end
                    end
                    default: ;
                endcase
            end
            case (state_r)
                IDLE: begin
                    if (runOk) begin
                        state_r    <= RUN;
                        workCnt_r  <= workCnt_nxt;
                        picStart_r <= wrPtr_r;
                        slices_r   <= 16'h0000;
                        if (!ring) begin
                            wrPtr_r    <= streamBase;
                            rdPtr_r    <= streamBase;
                            picStart_r <= streamBase;
                        end
                        qUsed_r <= qUsed_nxt;
                        pType_r <= pType_nxt;
                    end
                end
                RUN: begin
                    // no chunk is written while the buffer is full
                    if (full) begin
                        intStat_r[`INT_STALL] <= 1'b1;
                    end else if (workCnt_r == 16'h0000) begin
                        state_r    <= WRES;
                        pbIdx_r    <= 3'h0;
                        gopFirst_r <= 1'b0;
                    end else begin
                        workCnt_r <= workCnt_r - 16'h0001;
                        if (pType_r != `PTYPE_SKIP) begin
                            wrPtr_r  <= wrPtr_r + `CHUNK_BYTES;
                            slices_r <= slices_r + 16'h0001;
                        end
                    end
                end
                WRES: begin
                    pbIdx_r <= pbIdx_r + 3'h1;
                    if (done) begin
                        state_r <= HOLD;
                        intStat_r[`INT_PIC_DONE] <= 1'b1;
                    end
                end
                HOLD: begin
                    // results held until the host fetches them
                    if (wr && paddr == `OFS_RESFETCH) begin
                        state_r <= IDLE;
                    end
                end
                default: state_r <= IDLE;
            endcase
        end
    end

    // result word for the current parameter buffer slot
    always @* begin
        case (pbIdx_r)
            `PB_PTYPE:  pbWord_nxt = {30'h0, pType_r};
            `PB_SLICES: pbWord_nxt = {16'h0, slices_r};
            `PB_START:  pbWord_nxt = picStart_r;
            `PB_SIZE:   pbWord_nxt = wrPtr_r - picStart_r;
            `PB_SLBND:  pbWord_nxt = cfg_r[`CFG_REPORT] ? picStart_r + `CHUNK_BYTES : 32'h0;
            `PB_MBBND:  pbWord_nxt = cfg_r[`CFG_REPORT] ? {16'h0, `ENC_WORK} : 32'h0;
            `PB_QP:     pbWord_nxt = {26'h0, qUsed_r};
            default:    pbWord_nxt = {31'h0,
                            (std == `STD_H263) || (std == `STD_MPEG4)};
        endcase
    end

    // result words, one per cycle while writing results
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            parBuf_r[0] <= 32'h00000000;
            parBuf_r[1] <= 32'h00000000;
            parBuf_r[2] <= 32'h00000000;
            parBuf_r[3] <= 32'h00000000;
            parBuf_r[4] <= 32'h00000000;
            parBuf_r[5] <= 32'h00000000;
            parBuf_r[6] <= 32'h00000000;
            parBuf_r[7] <= 32'h00000000;
        end else if (state_r == WRES) begin
            parBuf_r[pbIdx_r] <= pbWord_nxt;
        end
    end
endmodule // video_encoder_picture_control

// File: pic_ctrl_chk.sv
// checker for the picture control block, bound in the bench top
// sees only the clock, reset, apb and interrupt ports of the block
`timescale 1ns/1ns
`include "pic_ctrl_defines.vh"
module pic_ctrl_chk (
    // clock and reset
    input wire        clk,
    input wire        rst_b,
    // apb
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire        pready,
    input wire [31:0] prdata,
    input wire        pslverr,
    // interrupt
    input wire        irq
);
    logic [31:0] enMask_r;
    logic        pend_r;
    wire         acc = psel && penable;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    sequence rdAt(a);
        acc && !pwrite && paddr == a;
    endsequence
    // completion seen by the host and not yet fetched
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            enMask_r <= 32'h0;
            pend_r <= 1'b0;
        end else begin
            if (acc && pwrite && paddr == `OFS_INTEN)
                enMask_r <= pwdata;
            if (acc && pwrite && paddr == `OFS_RESFETCH)
                pend_r <= 1'b0;
            else if (acc && !pwrite && paddr == `OFS_INTSTAT && prdata[3])
                pend_r <= 1'b1;
        end
    end
    chk_no_wait: assert property (acc |-> pready)
        else $error("access not answered");
    chk_err_phase: assert property (pslverr |-> acc)
        else $error("error outside access");
    chk_err_map: assert property (rdAt(12'h040) |-> pslverr)
        else $error("unmapped read not refused");
    chk_fmt_conv: assert property (rdAt(`OFS_CFG) ##0 prdata[6:4] == `FMT_422V
        |-> prdata[10:8] == `FMT_420) else $error("source not converted");
    chk_irq_src: assert property (rdAt(`OFS_INTSTAT) |-> irq == |(prdata & enMask_r))
        else $error("irq not status and mask");
    chk_irq_masked: assert property (enMask_r == 32'h0 |-> !irq)
        else $error("irq while masked");
    chk_fetch_first: assert property (rdAt(`OFS_BUSY) ##0 pend_r |-> !prdata[0])
        else $error("run before fetch");
    chk_stat_clear: assert property (rdAt(`OFS_INTSTAT) ##0 pend_r |-> !prdata[3])
        else $error("status not cleared");
endmodule // pic_ctrl_chk

// File: pic_host_model.sv
// host processor model: apb master tasks called by the bench
// assumes the bench clock; starts no transfer by itself
`timescale 1ns/1ns
`include "pic_ctrl_defines.vh"
module pic_host_model (
    // clock
    input wire          clk,
    // apb master
    output logic        psel,
    output logic        penable,
    output logic        pwrite,
    output logic [11:0] paddr,
    output logic [31:0] pwdata,
    input wire          pready,
    input wire  [31:0]  prdata,
    input wire          pslverr
);
    logic lastErr;
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h0;
        pwdata = 32'h0;
    end
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                        output logic [31:0] q);
        int n;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (n >= 16)
            video_encoder_picture_control_tb_top.hang();
        q = prdata;
        lastErr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // released lines must not keep the old value
        paddr <= ~a;
        pwdata <= ~d;
        @(posedge clk);
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        xfer(1'b1, a, d, q);
    endtask
    task automatic rd(input logic [11:0] a, output logic [31:0] q);
        xfer(1'b0, a, 32'h0, q);
    endtask
    task automatic runPic(input logic [31:0] q, input logic [31:0] o);
        wr(`OFS_YBASE, 32'h00002000);
        wr(`OFS_CBBASE, 32'h00003000);
        wr(`OFS_CRBASE, 32'h00003800);
        wr(`OFS_QSTEP, q);
        wr(`OFS_OPTS, o);
        wr(`OFS_CMD, {28'h0, `CMD_PIC_RUN});
    endtask
    task automatic drain();
        logic [31:0] q;
        rd(`OFS_WRPTR, q);
        wr(`OFS_RDPTR, q);
    endtask
endmodule // pic_host_model

// File: video_encoder_picture_control_tb_top.sv
// self-checking bench for the picture control block
// host model drives apb; checker bound at the foot
`timescale 1ns/1ns
`include "pic_ctrl_defines.vh"
module video_encoder_picture_control_tb_top;
    localparam logic [31:0] BASE = 32'h00001000;
    logic        clk, rst_b, psel, penable, pwrite, pready, pslverr, irq;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, streamBase, streamSize;
    int          nMismatch, testsRun;
    initial clk = 1'b0;
    always #2 clk = ~clk;
    pic_host_model h (.clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr));
    video_encoder_picture_control dut (.clk(clk), .rst_b(rst_b), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .irq(irq), .streamBase(streamBase),
        .streamSize(streamSize));
    task check(input logic [31:0] seen, input logic [31:0] exp);
        testsRun++;
        if (seen !== exp) begin
            nMismatch++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task rdc(input logic [11:0] a, input logic [31:0] exp, input logic [31:0] m);
        logic [31:0] q;
        h.rd(a, q);
        check(q & m, exp);
    endtask
    task waitIdle(input int lim, input logic dr);
        logic [31:0] q;
        for (int i = 0; i < lim; i++) begin
            h.rd(`OFS_BUSY, q);
            if (q[0] === 1'b0)
                return;
            if (dr)
                h.drain();
        end
        hang();
    endtask
    task scnBus();
        logic [31:0] q;
        h.rd(12'h040, q);
        check({31'h0, h.lastErr}, 32'h1);
        rdc(`OFS_BUSY, 32'h0, 32'h3);
        h.wr(`OFS_CMD, {28'h0, `CMD_PIC_RUN});
        rdc(`OFS_INTSTAT, 32'h1, 32'h1);
    endtask
    task scnFrame();
        h.wr(`OFS_CFG, 32'h20);
        rdc(`OFS_CFG, 32'h20, 32'h7f3);
        h.wr(`OFS_CMD, {28'h0, `CMD_SEQ_INIT});
        h.wr(`OFS_INTEN, 32'h8);
        h.runPic(32'h5, 32'h0);
        rdc(`OFS_BUSY, 32'h3, 32'h3);
        waitIdle(100, 1'b0);
        check({31'h0, irq}, 32'h1);
        rdc(`OFS_INTSTAT, 32'h8, 32'h8);
        check({31'h0, irq}, 32'h0);
        rdc(`OFS_PARBUF, {30'h0, `PTYPE_I}, 32'h3);
        rdc(12'h108, BASE, 32'hffffffff);
        rdc(12'h104, {16'h0, `ENC_WORK}, 32'hffffffff);
        rdc(12'h10c, `ENC_WORK * `CHUNK_BYTES, 32'hffffffff);
        rdc(12'h110, 32'h0, 32'hffffffff);
        rdc(12'h118, 32'h5, 32'h3f);
        rdc(12'h11c, 32'h0, 32'h1);
        h.wr(`OFS_RDPTR, 32'h00005550);
        rdc(`OFS_RDPTR, BASE, 32'hffffffff);
        h.runPic(32'h5, 32'h0);
        rdc(`OFS_INTSTAT, 32'h1, 32'h1);
        rdc(`OFS_BUSY, 32'h0, 32'h1);
        h.wr(`OFS_RESFETCH, 32'h0);
    endtask
    task scnTypes();
        // skip, plain, forced intra, then dynamic intra request
        for (int i = 0; i < 4; i++) begin
            if (i == 3) begin
                h.wr(`OFS_CMD, 32'h00000103);
                rdc(`OFS_DYNPARAM, 32'h00000103, 32'hffffffff);
            end
            h.runPic(32'h5, (32'h00000021 >> (2 * i)) & 32'h00000003);
            waitIdle(100, 1'b0);
            rdc(`OFS_PARBUF, (32'h06 >> (2 * i)) & 32'h3, 32'h3);
            rdc(12'h10c, (i == 0) ? 32'h0 : `ENC_WORK * `CHUNK_BYTES, 32'hffffffff);
            h.wr(`OFS_RESFETCH, 32'h0);
        end
    endtask
    task scnRing();
        h.wr(`OFS_CMD, {28'h0, `CMD_CLOSE});
        rdc(`OFS_BUSY, 32'h0, 32'h2);
        h.wr(`OFS_INTEN, 32'h0);
        h.wr(`OFS_CFG, 32'h8b);
        h.wr(`OFS_CMD, {28'h0, `CMD_SEQ_INIT});
        h.runPic(32'h5, 32'h0);
        repeat (40) @(posedge clk);
        rdc(`OFS_BUSY, 32'h1, 32'h1);
        rdc(`OFS_INTSTAT, 32'h2, 32'h2);
        waitIdle(400, 1'b1);
        rdc(12'h118, {26'h0, `QSTEP_RC}, 32'h3f);
        rdc(12'h11c, 32'h1, 32'h1);
        rdc(12'h10c, `ENC_WORK * `CHUNK_BYTES, 32'hffffffff);
        rdc(12'h110, BASE + `CHUNK_BYTES, 32'hffffffff);
        rdc(12'h114, {16'h0, `ENC_WORK}, 32'hffffffff);
        check({31'h0, irq}, 32'h0);
        h.wr(`OFS_RESFETCH, 32'h0);
    endtask
    task closeOut();
        $display("mismatches %0d comparisons %0d", nMismatch, testsRun);
        if (nMismatch == 0 && testsRun > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task hang();
        nMismatch++;
        closeOut();
    endtask
    initial begin
        rst_b = 1'b0;
        streamBase = BASE;
        streamSize = 32'h80;
        nMismatch = 0;
        testsRun = 0;
        repeat (4) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        scnBus();
        scnFrame();
        scnTypes();
        scnRing();
        closeOut();
    end
endmodule // video_encoder_picture_control_tb_top
bind video_encoder_picture_control pic_ctrl_chk u_chk (.clk(clk), .rst_b(rst_b),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .irq(irq));
